// *** logic/omc_defines.vh ***
// Constants of the operating-mode control block: offsets, fields, codes.
// Assumes a 32-bit APB with one register per aligned word.
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH

// Register indices; the byte address is four times the index.
`define OMC_IDX_MODE      8'h0B
`define OMC_IDX_STATUS    8'h0C
`define OMC_ADDR_MODE     12'h02C
`define OMC_ADDR_STATUS   12'h030

// Fields of operating_mode_control.
`define OMC_BIT_SPEC_N    7
`define OMC_BIT_SEL_B     6
`define OMC_BIT_SEL_A     5
`define OMC_BIT_STRETCH   4
`define OMC_BIT_VISIBLE   3
`define OMC_BIT_STOP_WAIT 2
`define OMC_BIT_EMUL_E    0

// Mode codes {special_mode_n, mode_select_b, mode_select_a}.
`define OMC_MODE_SSC      3'h0
`define OMC_MODE_SXN      3'h1
`define OMC_MODE_SPER     3'h2
`define OMC_MODE_SXW      3'h3
`define OMC_MODE_NSC      3'h4
`define OMC_MODE_NXN      3'h5
`define OMC_MODE_RSVD     3'h6
`define OMC_MODE_NXW      3'h7

// Port functions.
`define OMC_PORT_GPIO     2'h0
`define OMC_PORT_ADDR     2'h1
`define OMC_PORT_ADDATA   2'h2

// Debug address windows.
`define OMC_DBG_REG_LO    16'hFF00
`define OMC_DBG_REG_HI    16'hFF06
`define OMC_DBG_ROM_LO    16'hFF20
`define OMC_TOP_LO        16'hFF00

`endif

// *** logic/omc_mode_ctrl.v ***
// Operating-mode control: strap capture, mode register, bus configuration,
// register visibility and background debug mapping.
// Assumes a synchronous reset held at least four clocks and an APB master.
`timescale 1ns/1ps
`include "omc_defines.vh"

module omc_mode_ctrl (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        background_debug_pin,
    input  wire        mode_select_b,
    input  wire        mode_select_a,
    input  wire        debug_enable_cmd,
    input  wire        debug_serial_cmd,
    input  wire        background_instruction,
    input  wire        debug_exit,
    input  wire [15:0] cpu_addr,
    output wire        sel_debug_rom,
    output wire        sel_debug_regs,
    output wire        sel_user_top,
    output reg         background_debug_state,
    output reg  [1:0]  port_a_func,
    output reg  [1:0]  port_b_func,
    output reg         cpu_halted,
    output reg         port_ab_regs_mapped,
    output reg         port_e_regs_mapped,
    output reg         e_clock_stretch_out,
    output reg         visibility_out,
    input  wire        wait_mode,
    output reg         ext_bus_shutdown,
    input  wire        ext_req,
    input  wire        ext_word,
    input  wire [15:0] ext_req_addr,
    input  wire [15:0] ext_req_data,
    output wire        ext_done,
    output reg         ext_active,
    output reg  [15:0] ext_addr,
    output reg  [15:0] ext_data
);

    // External transfer sequencer states.
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_HIGH = 2'h1;
    localparam [1:0] ST_LOW  = 2'h2;

    function is_special;
        input [2:0] m;
        begin
            is_special = ~m[2];
        end
    endfunction

    function is_expanded;
        input [2:0] m;
        begin
            is_expanded = m[0];
        end
    endfunction

    function is_periph;
        input [2:0] m;
        begin
            is_periph = (m == `OMC_MODE_SPER);
        end
    endfunction

    // Three-stage pin synchroniser; only stages two and three are compared.
    reg [2:0] pin_s1_r;
    reg [2:0] pin_s2_r;
    reg [2:0] pin_s3_r;
    reg [2:0] pin_flt_r;
    reg       in_rst_r;
    reg [2:0] mode_r;
    reg       stretch_r;
    reg       visible_r;
    reg       stop_wait_r;
    reg       emul_e_r;
    reg       wr_seen_r;
    reg       dbg_en_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [15:0] lo_byte_r;

    always @(posedge clock) begin
        pin_s1_r <= {background_debug_pin, mode_select_b, mode_select_a};
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        if (pin_s2_r == pin_s3_r) begin
            pin_flt_r <= pin_s3_r;
        end
    end

    wire       setup_ph = psel & ~penable;
    wire       access   = psel & penable;
    wire       hit_mode = (paddr == `OMC_ADDR_MODE) & ~is_periph(mode_r);
    wire       hit_stat = (paddr == `OMC_ADDR_STATUS);
    wire       mode_wr  = access & pwrite & hit_mode;
    wire       special  = is_special(mode_r);
    wire [2:0] strap    = (pin_flt_r == `OMC_MODE_RSVD) ?
                          `OMC_MODE_SPER : pin_flt_r;
    wire [2:0] wr_mode  = {pwdata[`OMC_BIT_SPEC_N], pwdata[`OMC_BIT_SEL_B],
                           pwdata[`OMC_BIT_SEL_A]};
    wire       sel_ok   = ~pwdata[`OMC_BIT_SEL_B] | pwdata[`OMC_BIT_SEL_A];
    wire       first_ok = special ? wr_seen_r : ~wr_seen_r;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit_mode & ~hit_stat;

    // Mode register and write protection.
    always @(posedge clock) begin
        in_rst_r <= sys_rst;
        if (sys_rst) begin
            mode_r      <= `OMC_MODE_SSC;
            stretch_r   <= 1'b1;
            visible_r   <= 1'b0;
            stop_wait_r <= 1'b0;
            emul_e_r    <= 1'b0;
            wr_seen_r   <= 1'b0;
        end else if (in_rst_r) begin
            mode_r    <= strap;
            stretch_r <= 1'b1;
            visible_r <= is_special(strap);
            emul_e_r  <= is_special(strap);
        end else if (mode_wr) begin
            wr_seen_r <= 1'b1;
            if (special && wr_seen_r) begin
                mode_r[2] <= wr_mode[2];
            end
            if (first_ok && sel_ok) begin
                mode_r[1:0] <= wr_mode[1:0];
            end
            if (special || !wr_seen_r) begin
                stretch_r <= pwdata[`OMC_BIT_STRETCH];
            end
            if (first_ok) begin
                visible_r <= pwdata[`OMC_BIT_VISIBLE];
                emul_e_r  <= pwdata[`OMC_BIT_EMUL_E];
            end
            if (!special) begin
                stop_wait_r <= pwdata[`OMC_BIT_STOP_WAIT];
            end
        end
    end

    wire expanded   = is_expanded(mode_r) | is_periph(mode_r);
    wire stretch_rd = stretch_r | is_expanded(mode_r);
    wire e_hidden   = is_expanded(mode_r) & emul_e_r;

    // Read data is captured in the setup phase and held through access.
    always @(posedge clock) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            if (hit_mode) begin
                prdata <= {24'h000000, mode_r, stretch_rd, visible_r,
                           stop_wait_r, 1'b0, emul_e_r};
            end else if (hit_stat) begin
                prdata <= {26'h0, ext_bus_shutdown, mode_r,
                           dbg_en_r, background_debug_state};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Background debug enable and activation.
    always @(posedge clock) begin
        if (sys_rst) begin
            dbg_en_r               <= 1'b0;
            background_debug_state <= 1'b0;
        end else if (in_rst_r) begin
            dbg_en_r               <= (strap == `OMC_MODE_SSC);
            background_debug_state <= (strap == `OMC_MODE_SSC);
        end else begin
            if (debug_enable_cmd) begin
                dbg_en_r <= 1'b1;
            end
            if (background_debug_state && debug_exit) begin
                background_debug_state <= 1'b0;
            end else if (dbg_en_r &&
                         (debug_serial_cmd || background_instruction)) begin
                background_debug_state <= 1'b1;
            end
        end
    end

    // Debug ROM takes precedence over the user top page while active.
    assign sel_debug_rom  = background_debug_state &
                            (cpu_addr >= `OMC_DBG_ROM_LO);
    assign sel_debug_regs = background_debug_state &
                            (cpu_addr >= `OMC_DBG_REG_LO) &
                            (cpu_addr <= `OMC_DBG_REG_HI);
    assign sel_user_top   = ~background_debug_state &
                            (cpu_addr >= `OMC_TOP_LO);

    // Port and bus configuration, registered from the current mode.
    always @(posedge clock) begin
        if (sys_rst) begin
            port_a_func         <= `OMC_PORT_GPIO;
            port_b_func         <= `OMC_PORT_GPIO;
            cpu_halted          <= 1'b0;
            port_ab_regs_mapped <= 1'b1;
            port_e_regs_mapped  <= 1'b1;
            e_clock_stretch_out <= 1'b0;
            visibility_out      <= 1'b0;
        end else begin
            if (!expanded) begin
                port_a_func <= `OMC_PORT_GPIO;
                port_b_func <= `OMC_PORT_GPIO;
            end else if (mode_r[1] || is_periph(mode_r)) begin
                port_a_func <= `OMC_PORT_ADDATA;
                port_b_func <= `OMC_PORT_ADDATA;
            end else begin
                port_a_func <= `OMC_PORT_ADDATA;
                port_b_func <= `OMC_PORT_ADDR;
            end
            cpu_halted          <= is_periph(mode_r);
            port_ab_regs_mapped <= ~expanded;
            port_e_regs_mapped  <= ~(is_periph(mode_r) |
                                     e_hidden);
            e_clock_stretch_out <= stretch_rd;
            visibility_out      <= visible_r & is_expanded(mode_r);
        end
    end

    // Stop-in-wait: shut down only once no external transfer is running.
    always @(posedge clock) begin
        if (sys_rst) begin
            ext_bus_shutdown <= 1'b0;
        end else if (!(wait_mode && stop_wait_r)) begin
            ext_bus_shutdown <= 1'b0;
        end else if (st_r == ST_IDLE && !ext_req) begin
            ext_bus_shutdown <= 1'b1;
        end
    end

    // External transfer sequencer; a narrow word takes two bus cycles.
    wire go     = ext_req & expanded & ~ext_bus_shutdown;
    wire narrow = is_expanded(mode_r) & ~mode_r[1];

    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (go) begin
                    st_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (narrow && ext_word) begin
                    st_nxt = ST_LOW;
                end else begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_LOW: begin
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    assign ext_done = (st_r == ST_LOW) |
                      ((st_r == ST_HIGH) & (st_nxt == ST_IDLE));

    always @(posedge clock) begin
        if (sys_rst) begin
            st_r       <= ST_IDLE;
            ext_active <= 1'b0;
            ext_addr   <= 16'h0000;
            ext_data   <= 16'h0000;
            lo_byte_r  <= 16'h0000;
        end else begin
            st_r       <= st_nxt;
            ext_active <= (st_nxt != ST_IDLE);
            if (st_r == ST_IDLE && go) begin
                ext_addr  <= ext_req_addr;
                lo_byte_r <= {ext_req_data[7:0], 8'h00};
                if (narrow) begin
                    ext_data <= {ext_req_data[15:8], 8'h00};
                end else begin
                    ext_data <= ext_req_data;
                end
            end else if (st_nxt == ST_LOW) begin
                ext_addr <= ext_addr + 16'h0001;
                ext_data <= lo_byte_r;
            end
        end
    end

endmodule // omc_mode_ctrl

// *** sim/omc_mode_ctrl_assertions.sv ***
// Concurrent checks on the ports of the operating-mode control block.
// Assumes the bind at the foot attaches it to every instance.
`timescale 1ns/1ps
module omc_mode_ctrl_chk (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        background_debug_state,
    input wire logic [15:0] cpu_addr,
    input wire logic        sel_debug_rom,
    input wire logic        sel_debug_regs,
    input wire logic        sel_user_top,
    input wire logic [1:0]  port_a_func,
    input wire logic [1:0]  port_b_func,
    input wire logic        cpu_halted,
    input wire logic        port_ab_regs_mapped,
    input wire logic        port_e_regs_mapped,
    input wire logic        e_clock_stretch_out,
    input wire logic        visibility_out,
    input wire logic        ext_active,
    input wire logic        ext_done,
    input wire logic [15:0] ext_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_hi_beat;
        ext_active && !ext_done && port_b_func == 2'h1;
    endsequence
    sequence s_lo_beat;
        ext_done && ext_addr == $past(ext_addr) + 16'h0001;
    endsequence
    property p_narrow;
        s_hi_beat |=> s_lo_beat;
    endproperty
    property p_rom;
        sel_debug_rom == (background_debug_state && cpu_addr >= 16'hFF20);
    endproperty
    property p_regs;
        sel_debug_regs == (background_debug_state && cpu_addr >= 16'hFF00
                           && cpu_addr <= 16'hFF06);
    endproperty
    property p_top;
        sel_user_top == (!background_debug_state && cpu_addr >= 16'hFF00);
    endproperty
    property p_single;
        port_a_func == 2'h0 |-> port_b_func == 2'h0 && port_ab_regs_mapped
                                && port_e_regs_mapped && !visibility_out;
    endproperty
    property p_bus;
        port_a_func != 2'h0 |-> port_a_func == 2'h2 && !port_ab_regs_mapped;
    endproperty
    property p_halt;
        cpu_halted |-> port_b_func == 2'h2 && !port_e_regs_mapped;
    endproperty
    property p_stay;
        cpu_halted |=> cpu_halted;
    endproperty
    property p_e_clk;
        port_a_func == 2'h2 && !cpu_halted |-> e_clock_stretch_out;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow beat");
    a_rom: assert property (p_rom) else $error("debug rom select");
    a_regs: assert property (p_regs) else $error("debug regs");
    a_top: assert property (p_top) else $error("user top select");
    a_single: assert property (p_single) else $error("gpio");
    a_bus: assert property (p_bus) else $error("bus ports");
    a_halt: assert property (p_halt) else $error("halted");
    a_stay: assert property (p_stay) else $error("left halt");
    a_e_clk: assert property (p_e_clk) else $error("stretch bit");
endmodule // omc_mode_ctrl_chk

bind omc_mode_ctrl omc_mode_ctrl_chk u_chk (
    .clock, .sys_rst, .background_debug_state, .cpu_addr, .sel_debug_rom,
    .sel_debug_regs, .sel_user_top, .port_a_func, .port_b_func,
    .cpu_halted, .port_ab_regs_mapped, .port_e_regs_mapped,
    .e_clock_stretch_out, .visibility_out, .ext_active, .ext_done,
    .ext_addr);

// *** sim/omc_ext_mem.sv ***
// Behavioural external memory on the multiplexed bus; logs each beat.
// Assumes a beat per cycle of ext_active, narrow bytes in the high half.
`timescale 1ns/1ps
module omc_ext_mem (
    input  wire logic        clock,
    input  wire logic        ext_active,
    input  wire logic [1:0]  port_b_func,
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] ext_data,
    output logic      [31:0] addr_log,
    output logic      [15:0] data_log
);
    always @(posedge clock) begin
        if (ext_active) begin
            addr_log <= {addr_log[15:0], ext_addr};
            // Narrow beats carry one byte each, high byte first.
            data_log <= (port_b_func == 2'h1) ?
                        {data_log[7:0], ext_data[15:8]} : ext_data;
        end
    end
endmodule // omc_ext_mem

// *** sim/tb_operating_mode_control.sv ***
// Self-checking bench for the operating-mode control block.
// Assumes APB reads answer in the access cycle with no wait state.
`timescale 1ns/1ps
`include "omc_defines.vh"
module tb_operating_mode_control;
    logic        clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        background_debug_pin = 0, mode_select_b = 0;
    logic        mode_select_a = 0, wait_mode = 0, ext_req = 0, ext_word = 0;
    logic [3:0]  dbg = 4'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, addr_log;
    logic [15:0] cpu_addr = 16'h0, ext_req_addr = 16'h0, ext_req_data = 16'h0;
    logic [15:0] data_log, ext_addr, ext_data;
    logic [31:0] prdata;
    logic [1:0]  port_a_func, port_b_func;
    logic        pready, pslverr, sel_debug_rom, sel_debug_regs, sel_user_top;
    logic        background_debug_state, cpu_halted, port_ab_regs_mapped;
    logic        port_e_regs_mapped, e_clock_stretch_out, visibility_out;
    logic        ext_bus_shutdown, ext_done, ext_active, sc;
    logic [2:0]  em;
    logic [64:0] q[$];
    logic [64:0] e;
    int          miscompares = 0, samples_checked = 0, seed = 32'h6FBF;

    omc_mode_ctrl u_omc_mode_ctrl (
        .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .background_debug_pin, .mode_select_b,
        .mode_select_a, .debug_enable_cmd(dbg[1]), .debug_serial_cmd(dbg[0]),
        .background_instruction(dbg[2]), .debug_exit(dbg[3]), .cpu_addr,
        .sel_debug_rom, .sel_debug_regs, .sel_user_top,
        .background_debug_state, .port_a_func, .port_b_func, .cpu_halted,
        .port_ab_regs_mapped, .port_e_regs_mapped, .e_clock_stretch_out,
        .visibility_out, .wait_mode, .ext_bus_shutdown, .ext_req, .ext_word,
        .ext_req_addr, .ext_req_data, .ext_done, .ext_active, .ext_addr,
        .ext_data);
    omc_ext_mem u_omc_ext_mem (.clock, .ext_active, .port_b_func, .ext_addr,
        .ext_data, .addr_log, .data_log);

    always #2 clock = ~clock;

    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task fail;
        miscompares++;
        test_done;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Reads queue {slverr, mask, data}; the watcher below compares.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [64:0] x);
        int n;
        n = 0;
        if (!w) q.push_back(x);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n == 20) fail;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    always @(posedge clock) begin
        if (psel && penable && !pwrite) begin
            e = q.pop_front();
            chk(pslverr, e[64]);
            chk(prdata & e[63:32], e[31:0]);
        end
    end
    task rst(input logic [2:0] s);
        {background_debug_pin, mode_select_b, mode_select_a} <= s;
        sys_rst <= 1;
        repeat (10) @(posedge clock);
        sys_rst <= 0;
        repeat (3) @(posedge clock);
    endtask
    task pulse(input logic [3:0] v);
        dbg <= v;
        @(posedge clock);
        dbg <= 4'h0;
        repeat (2) @(posedge clock);
    endtask
    task xfer;
        int n;
        n = 0;
        ext_req_addr <= 16'($random(seed));
        ext_req_data <= 16'($random(seed));
        ext_word <= 1;
        ext_req <= 1;
        do begin
            @(posedge clock);
            if (ext_active === 1'b1) ext_req <= 0;
            n++;
        end while (ext_done !== 1'b1 && n < 20);
        if (n == 20) fail;
        @(posedge clock);
    endtask

    initial begin
        // No debug traffic is sent while an external master owns the bus.
        for (int m = 0; m < 8; m++) begin
            em = (m == 6) ? `OMC_MODE_SPER : m[2:0];
            sc = em[1:0] == 2'h0;
            rst(m[2:0]);
            chk(port_a_func, sc ? `OMC_PORT_GPIO : `OMC_PORT_ADDATA);
            chk(port_b_func, sc ? `OMC_PORT_GPIO : em[1:0] == 2'h1 ?
                `OMC_PORT_ADDR : `OMC_PORT_ADDATA);
            chk(cpu_halted, em == `OMC_MODE_SPER);
            chk(background_debug_state, em == `OMC_MODE_SSC);
            chk(port_ab_regs_mapped, sc);
            chk(port_e_regs_mapped, em[2] | sc);
            chk(visibility_out, em[0] & ~em[2]);
            chk(e_clock_stretch_out, 1'b1);
            apb(0, `OMC_ADDR_STATUS, 0, {1'b0, 32'h3F, 26'h0, 1'b0, em,
                !m[2:0], !m[2:0]});
            if (em == `OMC_MODE_SPER)
                apb(0, `OMC_ADDR_MODE, 0, {1'b1, 32'hFFFFFFFF, 32'h0});
            else
                apb(0, `OMC_ADDR_MODE, 0, {1'b0, 32'hFF, 24'h0, em, 1'b1,
                    !em[2], 2'h0, !em[2]});
        end
        rst(`OMC_MODE_SXW);
        apb(1, `OMC_ADDR_MODE, 32'h30, 65'h0);
        @(posedge clock);
        chk(port_b_func, `OMC_PORT_ADDATA);
        apb(1, `OMC_ADDR_MODE, 32'h30, 65'h0);
        @(posedge clock);
        chk(port_b_func, `OMC_PORT_ADDR);
        apb(1, `OMC_ADDR_MODE, 32'h50, 65'h0);
        apb(0, `OMC_ADDR_MODE, 0, {1'b0, 32'hFF, 32'h30});
        xfer;
        chk(addr_log, {ext_req_addr, ext_req_addr + 16'h1});
        chk(data_log, ext_req_data);
        apb(1, `OMC_ADDR_MODE, 32'h70, 65'h0);
        @(posedge clock);
        xfer;
        chk(data_log, ext_req_data);
        rst(`OMC_MODE_NSC);
        apb(1, `OMC_ADDR_MODE, 32'h14, 65'h0);
        apb(1, `OMC_ADDR_MODE, 32'hB4, 65'h0);
        apb(0, `OMC_ADDR_MODE, 0, {1'b0, 32'hFF, 32'h94});
        apb(0, 12'h100, 0, {1'b1, 32'hFFFFFFFF, 32'h0});
        pulse(4'h1);
        chk(background_debug_state, 1'b0);
        pulse(4'h2);
        pulse(4'h4);
        chk(background_debug_state, 1'b1);
        repeat (20) begin
            cpu_addr <= {8'hFF, 8'($random(seed))};
            @(posedge clock);
        end
        pulse(4'h8);
        chk(background_debug_state, 1'b0);
        // The stop-in-wait bit was set by the normal-mode writes above.
        wait_mode <= 1'b1;
        repeat (2) @(posedge clock);
        chk(ext_bus_shutdown, 1'b1);
        wait_mode <= 1'b0;
        repeat (2) @(posedge clock);
        chk(ext_bus_shutdown, 1'b0);
        test_done;
    end
    initial begin
        #200000;
        fail;
    end
endmodule // tb_operating_mode_control
